// File: pio_pkg.sv
package pio_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Special function area bounds.
  localparam logic [15:0] SFA_FIRST = 16'h0000;
  localparam logic [15:0] SFA_LAST = 16'h003f;
  // Register offsets.
  localparam logic [5:0] OFS_P0_LATCH = 6'h00;
  localparam logic [5:0] OFS_P1_LATCH = 6'h01;
  localparam logic [5:0] OFS_P2_LATCH = 6'h02;
  localparam logic [5:0] OFS_P3_LATCH = 6'h03;
  localparam logic [5:0] OFS_P4_LATCH = 6'h04;
  localparam logic [5:0] OFS_P0_PINS = 6'h08;
  localparam logic [5:0] OFS_P2_PINS = 6'h0a;
  localparam logic [5:0] OFS_P1_DIR = 6'h0d;
  localparam logic [5:0] OFS_P3_DIR = 6'h0e;
  localparam logic [5:0] OFS_P4_DIR = 6'h0f;
  localparam logic [5:0] OFS_CONV_CTRL1 = 6'h1c;
  localparam logic [5:0] OFS_EXT_INT_CTRL = 6'h37;
  // Field positions.
  localparam int EXT_IRQ0_PIN_SELECT_BIT = 6;
  localparam int ANALOG_INPUT_DISABLE_BIT = 4;
  localparam int ANALOG_CHANNEL_SELECT_LSB = 0;
  localparam int ANALOG_CHANNEL_SELECT_W = 3;
  localparam int P2_WIDTH = 3;
  // Reset values.
  localparam logic [7:0] RST_OPEN_LATCH = 8'hff;
  localparam logic [7:0] RST_DIR_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_CONV_CTRL1 = 8'h10;
  localparam logic [7:0] RST_EXT_INT_CTRL = 8'h00;
endpackage

// File: pio_latch_port.sv
`timescale 1ns/100ps
// Fixed output latch port: the pin is pulled low when the latch bit is 0 and its drive_mask bit is 1.
module pio_latch_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_latch,
  input wire logic [7:0] wdata,
  input wire logic [7:0] drive_mask,
  output logic [7:0] latch_q,
  output logic [7:0] oe_q
);
  logic [7:0] latch_d;

  assign latch_d = wr_latch ? wdata : latch_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_q <= pio_pkg::RST_OPEN_LATCH;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Drive enable tracks the next latch value so the pin moves with the latch.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_q <= 8'h00;
    end else begin
      oe_q <= ~latch_d & drive_mask;
    end
  end
endmodule // pio_latch_port

// File: pio_dir_port.sv
`timescale 1ns/100ps
// Direction-controlled port with per-bit analog override.
module pio_dir_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic [7:0] wdata,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] ana_mask,
  output logic [7:0] latch_q,
  output logic [7:0] dir_q,
  output logic [7:0] oe_q,
  output logic [7:0] rd_val
);
  logic [7:0] latch_d;
  logic [7:0] dir_d;

  assign latch_d = wr_latch ? wdata : latch_q;
  assign dir_d = wr_dir ? wdata : dir_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_q <= pio_pkg::RST_DIR_LATCH;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_q <= pio_pkg::RST_DIR;
    end else begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_q <= 8'h00;
    end else begin
      oe_q <= dir_d & ~ana_mask;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // An analog pin reads 0; otherwise input mode reads the pin, output the latch.
      assign rd_val[i] = ana_mask[i] ? 1'b0 : (dir_q[i] ? latch_q[i] : pin_in[i]);
    end
  endgenerate
endmodule // pio_dir_port

// File: pio_ports.sv
`timescale 1ns/100ps
module pio_ports (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [15:0] BUS_ADDR,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic BUS_FIRST_STATE,
  input wire logic BUS_SECOND_STATE,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  input wire logic DUAL_CLK_MODE,
  input wire logic [7:0] P0_IN,
  output logic [7:0] P0_OUT,
  output logic [7:0] P0_OE,
  input wire logic [7:0] P1_IN,
  output logic [7:0] P1_OUT,
  output logic [7:0] P1_OE,
  input wire logic [2:0] P2_IN,
  output logic [2:0] P2_OUT,
  output logic [2:0] P2_OE,
  input wire logic [7:0] P3_IN,
  output logic [7:0] P3_OUT,
  output logic [7:0] P3_OE,
  input wire logic [7:0] P4_IN,
  output logic [7:0] P4_OUT,
  output logic [7:0] P4_OE,
  output logic EXT_IRQ0_N,
  output logic P2_0_FALL,
  output logic ANALOG_INPUT_DISABLE,
  output logic [2:0] ANALOG_CHANNEL_SELECT
);
  ////////////////////////////////////////////////////////////////////////////////
  logic in_window;
  logic [5:0] ofs;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] conv_ctrl1_q;
  logic [7:0] ext_int_ctrl_q;
  logic [7:0] p0_latch;
  logic [7:0] p0_oe;
  logic [7:0] p2_latch;
  logic [7:0] p2_oe;
  logic [7:0] p2_mask;
  logic [7:0] p1_latch;
  logic [7:0] p1_dir;
  logic [7:0] p1_oe;
  logic [7:0] p1_rd;
  logic [7:0] p3_latch;
  logic [7:0] p3_dir;
  logic [7:0] p3_oe;
  logic [7:0] p3_rd;
  logic [7:0] p4_latch;
  logic [7:0] p4_dir;
  logic [7:0] p4_oe;
  logic [7:0] p4_rd;
  logic [7:0] ana_mask;
  logic ana_en;
  logic [2:0] ana_sel;
  logic [7:0] conv_ctrl1_d;
  logic [7:0] p2_latch_rd;
  logic [7:0] p2_pins_rd;
  logic wr_p0_latch;
  logic wr_p1_latch;
  logic wr_p2_latch;
  logic wr_p3_latch;
  logic wr_p4_latch;
  logic wr_p1_dir;
  logic wr_p3_dir;
  logic wr_p4_dir;
  logic wr_conv_ctrl1;
  logic wr_ext_int_ctrl;
  logic [7:0] rd_d;
  logic p20_prev_q;

  assign in_window = (BUS_ADDR >= pio_pkg::SFA_FIRST) && (BUS_ADDR <= pio_pkg::SFA_LAST);
  assign ofs = BUS_ADDR[5:0];
  assign wr_stb = BUS_WR && BUS_SECOND_STATE && in_window;
  assign rd_stb = BUS_RD && BUS_FIRST_STATE && in_window;

  ////////////////////////////////////////////////////////////////////////////////
  // One write strobe per register keeps the address decode in one place.
  assign wr_p0_latch = wr_stb && (ofs == pio_pkg::OFS_P0_LATCH);
  assign wr_p1_latch = wr_stb && (ofs == pio_pkg::OFS_P1_LATCH);
  assign wr_p2_latch = wr_stb && (ofs == pio_pkg::OFS_P2_LATCH);
  assign wr_p3_latch = wr_stb && (ofs == pio_pkg::OFS_P3_LATCH);
  assign wr_p4_latch = wr_stb && (ofs == pio_pkg::OFS_P4_LATCH);
  assign wr_p1_dir = wr_stb && (ofs == pio_pkg::OFS_P1_DIR);
  assign wr_p3_dir = wr_stb && (ofs == pio_pkg::OFS_P3_DIR);
  assign wr_p4_dir = wr_stb && (ofs == pio_pkg::OFS_P4_DIR);
  assign wr_conv_ctrl1 = wr_stb && (ofs == pio_pkg::OFS_CONV_CTRL1);
  assign wr_ext_int_ctrl = wr_stb && (ofs == pio_pkg::OFS_EXT_INT_CTRL);

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits that steer the pins, held at their own addresses.
  assign conv_ctrl1_d = wr_conv_ctrl1 ? BUS_WDATA : conv_ctrl1_q;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      conv_ctrl1_q <= pio_pkg::RST_CONV_CTRL1;
    end else begin
      conv_ctrl1_q <= conv_ctrl1_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_int_ctrl_q <= pio_pkg::RST_EXT_INT_CTRL;
    end else if (wr_ext_int_ctrl) begin
      ext_int_ctrl_q <= BUS_WDATA;
    end
  end

  // The mask follows the next control value, so a newly chosen analog pin
  // is never driven, not even for the cycle its driver needs to let go.
  assign ana_en = ~conv_ctrl1_d[pio_pkg::ANALOG_INPUT_DISABLE_BIT];
  assign ana_sel = conv_ctrl1_d[pio_pkg::ANALOG_CHANNEL_SELECT_LSB +:
                                pio_pkg::ANALOG_CHANNEL_SELECT_W];

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_ana
      assign ana_mask[ch] = ana_en && (ana_sel == 3'(ch));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Crystal pins of port 2 are released in dual-clock mode.
  assign p2_mask = {5'h00, ~DUAL_CLK_MODE, ~DUAL_CLK_MODE, 1'b1};

  pio_latch_port u_p0 (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .wr_latch(wr_p0_latch),
    .wdata(BUS_WDATA),
    .drive_mask(8'hff),
    .latch_q(p0_latch),
    .oe_q(p0_oe)
  );

  pio_latch_port u_p2 (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .wr_latch(wr_p2_latch),
    .wdata(BUS_WDATA),
    .drive_mask(p2_mask),
    .latch_q(p2_latch),
    .oe_q(p2_oe)
  );

  pio_dir_port u_p1 (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .wr_latch(wr_p1_latch),
    .wr_dir(wr_p1_dir),
    .wdata(BUS_WDATA),
    .pin_in(P1_IN),
    .ana_mask(8'h00),
    .latch_q(p1_latch),
    .dir_q(p1_dir),
    .oe_q(p1_oe),
    .rd_val(p1_rd)
  );

  pio_dir_port u_p3 (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .wr_latch(wr_p3_latch),
    .wr_dir(wr_p3_dir),
    .wdata(BUS_WDATA),
    .pin_in(P3_IN),
    .ana_mask(ana_mask),
    .latch_q(p3_latch),
    .dir_q(p3_dir),
    .oe_q(p3_oe),
    .rd_val(p3_rd)
  );

  pio_dir_port u_p4 (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .wr_latch(wr_p4_latch),
    .wr_dir(wr_p4_dir),
    .wdata(BUS_WDATA),
    .pin_in(P4_IN),
    .ana_mask(8'h00),
    .latch_q(p4_latch),
    .dir_q(p4_dir),
    .oe_q(p4_oe),
    .rd_val(p4_rd)
  );

  assign P0_OUT = p0_latch;
  assign P0_OE = p0_oe;
  assign P1_OUT = p1_latch;
  assign P1_OE = p1_oe;
  assign P2_OUT = p2_latch[2:0];
  assign P2_OE = p2_oe[2:0];
  assign P3_OUT = p3_latch;
  assign P3_OE = p3_oe;
  assign P4_OUT = p4_latch;
  assign P4_OE = p4_oe;
  assign ANALOG_INPUT_DISABLE = conv_ctrl1_q[pio_pkg::ANALOG_INPUT_DISABLE_BIT];
  assign ANALOG_CHANNEL_SELECT = conv_ctrl1_q[2:0];

  ////////////////////////////////////////////////////////////////////////////////
  // The upper five bits of port 2 read as zero; software must not rely on them.
  assign p2_latch_rd = {5'h00, p2_latch[pio_pkg::P2_WIDTH-1:0]};
  assign p2_pins_rd = {5'h00, P2_IN};

  // Read mux; unused and unmapped offsets read zero.
  always_comb begin
    rd_d = 8'h00;
    unique case (ofs)
      pio_pkg::OFS_P0_LATCH: rd_d = p0_latch;
      pio_pkg::OFS_P1_LATCH: rd_d = p1_rd;
      pio_pkg::OFS_P2_LATCH: rd_d = p2_latch_rd;
      pio_pkg::OFS_P3_LATCH: rd_d = p3_rd;
      pio_pkg::OFS_P4_LATCH: rd_d = p4_rd;
      pio_pkg::OFS_P0_PINS: rd_d = P0_IN;
      pio_pkg::OFS_P2_PINS: rd_d = p2_pins_rd;
      pio_pkg::OFS_P1_DIR: rd_d = p1_dir;
      pio_pkg::OFS_P3_DIR: rd_d = p3_dir;
      pio_pkg::OFS_P4_DIR: rd_d = p4_dir;
      pio_pkg::OFS_CONV_CTRL1: rd_d = conv_ctrl1_q;
      pio_pkg::OFS_EXT_INT_CTRL: rd_d = ext_int_ctrl_q;
      default: rd_d = 8'h00;
    endcase
  end

  // Pins are caught once, in the first state; software must debounce chatter.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_RDATA <= 8'h00;
    end else if (rd_stb) begin
      BUS_RDATA <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt pin routing: idle high when the pin is an ordinary port bit.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      EXT_IRQ0_N <= 1'b1;
    end else begin
      EXT_IRQ0_N <= ext_int_ctrl_q[pio_pkg::EXT_IRQ0_PIN_SELECT_BIT] ? P0_IN[0] : 1'b1;
    end
  end

  // The edge is seen on the pin itself, so a self-driven falling edge counts too.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p20_prev_q <= 1'b1;
    end else begin
      p20_prev_q <= P2_IN[0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      P2_0_FALL <= 1'b0;
    end else begin
      P2_0_FALL <= p20_prev_q & ~P2_IN[0];
    end
  end
endmodule // pio_ports

// File: pio_pin_model.sv
`timescale 1ns/100ps
// External circuit on a port: it drives a level on every pin and yields where the port drives.
module pio_pin_model #(
  parameter int W = 8,
  parameter bit OD = 1'b0
) (
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  // Open-drain ports only pull low, so the high level always comes from outside.
  assign pin = OD ? (ext & ~oe) : ((out & oe) | (ext & ~oe));
endmodule // pio_pin_model

// File: pio_ports_monitor.sv
`timescale 1ns/100ps
module pio_ports_monitor (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [15:0] BUS_ADDR,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic BUS_FIRST_STATE,
  input wire logic BUS_SECOND_STATE,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  input wire logic [7:0] P0_IN,
  input wire logic [7:0] P0_OUT,
  input wire logic [7:0] P1_OUT,
  input wire logic [7:0] P1_OE,
  input wire logic [2:0] P2_IN,
  input wire logic [7:0] P3_OE,
  input wire logic EXT_IRQ0_N,
  input wire logic P2_0_FALL,
  input wire logic ANALOG_INPUT_DISABLE,
  input wire logic [2:0] ANALOG_CHANNEL_SELECT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////
  sequence s_wr(logic [15:0] a); BUS_WR && BUS_SECOND_STATE && BUS_ADDR == a; endsequence
  sequence s_rd(logic [15:0] a); BUS_RD && BUS_FIRST_STATE && BUS_ADDR == a; endsequence
  ////////////////////////////////////////
  property p_wr; s_wr(16'h0001) |=> P1_OUT == $past(BUS_WDATA); endproperty
  a_wr: assert property (p_wr) else $error("latch write lost");
  property p_dir; s_wr(16'h000d) |=> P1_OE == $past(BUS_WDATA); endproperty
  a_dir: assert property (p_dir) else $error("drive enable wrong");
  property p_pins0; s_rd(16'h0008) |=> BUS_RDATA == $past(P0_IN); endproperty
  a_pins0: assert property (p_pins0) else $error("pin read wrong");
  property p_pins2; s_rd(16'h000a) |=> BUS_RDATA[2:0] == $past(P2_IN); endproperty
  a_pins2: assert property (p_pins2) else $error("port 2 pin read");
  property p_oob; BUS_WR && BUS_SECOND_STATE && BUS_ADDR > 16'h003f
    |=> $stable(P0_OUT) && $stable(P1_OUT); endproperty
  a_oob: assert property (p_oob) else $error("write outside window");
  property p_irq; !EXT_IRQ0_N |-> $past(P0_IN[0]) == 1'b0; endproperty
  a_irq: assert property (p_irq) else $error("irq without low pin");
  property p_fall; $fell(P2_IN[0]) |-> ##[1:3] P2_0_FALL; endproperty
  a_fall: assert property (p_fall) else $error("fall not flagged");
  // The driver must let go in the same cycle that the pin becomes analog.
  property p_ana; !ANALOG_INPUT_DISABLE |-> !P3_OE[ANALOG_CHANNEL_SELECT]; endproperty
  a_ana: assert property (p_ana) else $error("analog pin driven");
endmodule // pio_ports_monitor
bind pio_ports pio_ports_monitor i_mon (.*);

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic CORE_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic BUS_RD = 1'b0, BUS_WR = 1'b0, BUS_FIRST_STATE = 1'b0, BUS_SECOND_STATE = 1'b0;
  logic DUAL_CLK_MODE = 1'b0;
  logic [15:0] BUS_ADDR = 16'h0000;
  logic [7:0] BUS_WDATA = 8'h00, e0 = 8'hff, ex = 8'ha5, d;
  logic [2:0] e2 = 3'h7;
  logic [7:0] BUS_RDATA, P0_IN, P0_OUT, P0_OE, P1_IN, P1_OUT, P1_OE, P3_IN, P3_OUT, P3_OE;
  logic [7:0] P4_IN, P4_OUT, P4_OE;
  logic [2:0] P2_IN, P2_OUT, P2_OE, ANALOG_CHANNEL_SELECT;
  logic EXT_IRQ0_N, P2_0_FALL, ANALOG_INPUT_DISABLE;
  logic [15:0] lat[3] = '{16'h0001, 16'h0003, 16'h0004};
  logic [15:0] dir[3] = '{16'h000d, 16'h000e, 16'h000f};
  int fails = 0, num_checks = 0;
  pio_ports i_pio_ports (.*);
  pio_pin_model #(.OD(1'b1)) m0 (.out(P0_OUT), .oe(P0_OE), .ext(e0), .pin(P0_IN));
  pio_pin_model m1 (.out(P1_OUT), .oe(P1_OE), .ext(ex), .pin(P1_IN));
  pio_pin_model #(.W(3), .OD(1'b1)) m2 (.out(P2_OUT), .oe(P2_OE), .ext(e2), .pin(P2_IN));
  pio_pin_model m3 (.out(P3_OUT), .oe(P3_OE), .ext(ex), .pin(P3_IN));
  pio_pin_model m4 (.out(P4_OUT), .oe(P4_OE), .ext(ex), .pin(P4_IN));
  initial forever #10 CORE_CLK = ~CORE_CLK;
  ////////////////////////////////////////
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // One first-state/second-state pair; the pause lets the closing edge's updates land.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge CORE_CLK);
    BUS_WR <= w;
    BUS_RD <= !w;
    BUS_ADDR <= a;
    BUS_WDATA <= v;
    BUS_FIRST_STATE <= 1'b1;
    @(posedge CORE_CLK);
    BUS_FIRST_STATE <= 1'b0;
    BUS_SECOND_STATE <= 1'b1;
    @(posedge CORE_CLK);
    BUS_WR <= 1'b0;
    BUS_RD <= 1'b0;
    BUS_SECOND_STATE <= 1'b0;
    #1;
    d = BUS_RDATA;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] exp, input string n);
    bus(1'b0, a, 8'h00);
    chk(n, exp, d);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge CORE_CLK);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    #1;
    chk("p0out", 8'hff, P0_OUT);
    chk("p2out", 8'h07, {5'h00, P2_OUT});
    chk("p134out", 8'h00, P1_OUT | P3_OUT | P4_OUT);
    chk("oe", 8'h00, P0_OE | P1_OE | {5'h00, P2_OE} | P3_OE | P4_OE);
    chk("aindis", 8'h01, {7'h00, ANALOG_INPUT_DISABLE});
    rc(16'h0000, 8'hff, "p0lat");
    for (int i = 0; i < 3; i++) begin
      rc(lat[i], 8'ha5, "inpins");
      bus(1'b1, lat[i], 8'h3c);
      rc(lat[i], 8'ha5, "preload");
      bus(1'b1, dir[i], 8'hf0);
      rc(lat[i], 8'h35, "mixed");
    end
    chk("p1oe", 8'hf0, P1_OE);
    chk("p4out", 8'h3c, P4_OUT);
    @(posedge CORE_CLK);
    ex <= 8'h5a;
    rc(16'h0004, 8'h3a, "p4live");
    bus(1'b1, 16'h0000, 8'h0f);
    chk("p0oe", 8'hf0, P0_OE);
    rc(16'h0008, 8'h0f, "p0pins");
    bus(1'b1, 16'h0002, 8'h06);
    @(posedge CORE_CLK);
    #1;
    chk("p2fall", 8'h01, {7'h00, P2_0_FALL});
    @(posedge CORE_CLK);
    #1;
    chk("p2fall1", 8'h00, {7'h00, P2_0_FALL});
    bus(1'b0, 16'h000a, 8'h00);
    chk("p2pins", 8'h06, {5'h00, d[2:0]});
    bus(1'b1, 16'h0040, 8'h00);
    bus(1'b1, 16'h0008, 8'h00);
    chk("p0keep", 8'h0f, P0_OUT);
    rc(16'h0005, 8'h00, "rsvd");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 16'h001c, 8'(c));
      chk("p3oe", 8'hf0 & ~(8'h01 << c), P3_OE);
      chk("p3sel", 8'(c), {5'h00, ANALOG_CHANNEL_SELECT});
      rc(16'h0003, 8'h3a & ~(8'h01 << c), "p3ana");
    end
    chk("aindis0", 8'h00, {7'h00, ANALOG_INPUT_DISABLE});
    bus(1'b1, 16'h001c, 8'h10);
    rc(16'h0003, 8'h3a, "p3dig");
    bus(1'b1, 16'h0037, 8'h40);
    @(posedge CORE_CLK);
    e0 <= 8'hfe;
    repeat (3) @(posedge CORE_CLK);
    #1;
    chk("irqsel", 8'h00, {7'h00, EXT_IRQ0_N});
    bus(1'b1, 16'h0037, 8'h00);
    repeat (2) @(posedge CORE_CLK);
    #1;
    chk("irqoff", 8'h01, {7'h00, EXT_IRQ0_N});
    bus(1'b1, 16'h0001, 8'hff);
    bus(1'b1, 16'h000d, 8'hff);
    chk("p1tmr", 8'hff, P1_OUT & P1_OE);
    rc(16'h0001, 8'hff, "p1out");
    bus(1'b1, 16'h0002, 8'h00);
    chk("p2oe", 8'h07, {5'h00, P2_OE});
    @(posedge CORE_CLK);
    DUAL_CLK_MODE <= 1'b1;
    e2 <= 3'h5;
    repeat (2) @(posedge CORE_CLK);
    #1;
    chk("p2dual", 8'h01, {5'h00, P2_OE});
    bus(1'b0, 16'h000a, 8'h00);
    chk("p2xtal", 8'h04, {5'h00, d[2:0]});
    @(posedge CORE_CLK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    #1;
    chk("p0rst", 8'hff, P0_OUT);
    chk("p14rst", 8'h00, P1_OUT | P1_OE | P4_OUT | P4_OE);
    chk("p3rst", 8'h00, P3_OE);
    chk("aindis1", 8'h01, {7'h00, ANALOG_INPUT_DISABLE});
    rc(16'h0001, 8'h5a, "p1after");
    end_of_test();
  end
endmodule // tb
